// >>> prescaled_timer_chain.sv
// Purpose: Prescaler, timers 1 to 3, free 16-bit timer and watchdog count.
// Assumes: AXI4-Lite slave on aclk; instruction clock is aclk divided.
// Notes: Timer source code 11 of timer 3 gives no count pulses.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module prescaled_timer_chain
  import timer_chain_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic carrier_out,
  output logic timer_out,
  output logic timer_out_select,
  output logic watchdog_expired
);
  logic [3:0] prescaler_timer1_control, timer2_control;
  logic [4:0] timer3_control;
  logic [1:0] timer1_high_bits_holder, wdt_count;
  logic [9:0] reload1, count1;
  logic [7:0] reload2, reload3, count2, count3;
  logic [IRQ_BITS-1:0] irq_status, irq_mask, events;
  logic aw_held, w_held, do_write, lane0, do_read, read_hit, write_hit;
  logic [5:0] aw_addr;
  logic [31:0] w_data, read_value;
  logic [3:0] w_strb, instr_div_count;
  logic [2:0] prescaler_count;
  logic [T16_WIDTH-1:0] timer16;
  logic instr_tick, prescaler_output, oscillator_input, osc_half, wdt_enable;
  logic t16_underflow, t16_watch_prev, wdt_step, carrier, carrier_gate, carrier_rise;
  logic tick1, tick2, tick3, load1, load2, load3, uf1, uf2, uf3;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign lane0 = w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    unique case ({aw_addr[5:2], 2'b00})
      OFF_PRESCALER_TIMER1_CONTROL, OFF_TIMER2_CONTROL, OFF_TIMER3_CONTROL,
      OFF_TIMER1_LOAD, OFF_TIMER1_HIGH_BITS_HOLDER, OFF_TIMER2_LOAD,
      OFF_TIMER3_LOAD, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_WATCHDOG: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic wr(input logic [5:0] off);
    wr = do_write && lane0 && ({aw_addr[5:2], 2'b00} == off);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler_timer1_control <= 4'h0;
      timer2_control <= 4'h0;
      timer3_control <= 5'h00;
      irq_mask <= '0;
      wdt_enable <= 1'b0;
    end else begin
      if (wr(OFF_PRESCALER_TIMER1_CONTROL)) prescaler_timer1_control <= w_data[3:0];
      if (wr(OFF_TIMER2_CONTROL)) timer2_control <= w_data[3:0];
      if (wr(OFF_TIMER3_CONTROL)) timer3_control <= w_data[4:0];
      if (wr(OFF_IRQ_MASK)) irq_mask <= w_data[IRQ_BITS-1:0];
      if (wr(OFF_WATCHDOG)) wdt_enable <= w_data[WDT_ENABLE_BIT];
    end
  end

  // Holder feeds timer 1 upper bits on load and catches them on a count read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer1_high_bits_holder <= 2'h0;
    end else if (wr(OFF_TIMER1_HIGH_BITS_HOLDER)) begin
      timer1_high_bits_holder <= w_data[1:0];
    end else if (do_read && ({s_axi_araddr[5:2], 2'b00} == OFF_TIMER1_COUNT)) begin
      timer1_high_bits_holder <= count1[9:8];
    end
  end

  assign load1 = wr(OFF_TIMER1_LOAD);
  assign load2 = wr(OFF_TIMER2_LOAD);
  assign load3 = wr(OFF_TIMER3_LOAD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload1 <= 10'h000;
      reload2 <= 8'h00;
      reload3 <= 8'h00;
    end else begin
      if (load1) reload1 <= {timer1_high_bits_holder, w_data[7:0]};
      if (load2) reload2 <= w_data[7:0];
      if (load3) reload3 <= w_data[7:0];
    end
  end

  // Read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_comb begin
    read_value = 32'h00000000;
    read_hit = 1'b1;
    unique case ({s_axi_araddr[5:2], 2'b00})
      OFF_PRESCALER_TIMER1_CONTROL: read_value[3:0] = prescaler_timer1_control;
      OFF_TIMER2_CONTROL: read_value[3:0] = timer2_control;
      OFF_TIMER3_CONTROL: read_value[4:0] = timer3_control;
      OFF_TIMER1_LOAD: read_value[7:0] = reload1[7:0];
      OFF_TIMER1_HIGH_BITS_HOLDER: read_value[1:0] = timer1_high_bits_holder;
      OFF_TIMER2_LOAD: read_value[7:0] = reload2;
      OFF_TIMER3_LOAD: read_value[7:0] = reload3;
      OFF_TIMER1_COUNT: read_value[7:0] = count1[7:0];
      OFF_TIMER2_COUNT: read_value[7:0] = count2;
      OFF_TIMER3_COUNT: read_value[7:0] = count3;
      OFF_TIMER16_COUNT: read_value[15:0] = timer16;
      OFF_IRQ_STATUS: read_value[IRQ_BITS-1:0] = irq_status;
      OFF_IRQ_MASK: read_value[IRQ_BITS-1:0] = irq_mask;
      OFF_WATCHDOG: read_value[3:0] = {wdt_count, 1'b0, wdt_enable};
      default: read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Instruction clock enable
  assign instr_tick = (instr_div_count == INSTR_DIV - 4'h1);
  always_ff @(posedge aclk) begin
    if (!aresetn || instr_tick) begin
      instr_div_count <= 4'h0;
    end else begin
      instr_div_count <= instr_div_count + 4'h1;
    end
  end

  // Prescaler; stopping it returns it to its initial state
  always_ff @(posedge aclk) begin
    if (!aresetn || !prescaler_timer1_control[PRE_RUN_BIT]) begin
      prescaler_count <= 3'h0;
      prescaler_output <= 1'b0;
    end else begin
      prescaler_output <= 1'b0;
      if (instr_tick) begin
        if (prescaler_count == (prescaler_timer1_control[PRE_RATIO_BIT] ?
                                PRE_DIV8_LAST : PRE_DIV4_LAST)) begin
          prescaler_count <= 3'h0;
          prescaler_output <= 1'b1;
        end else begin
          prescaler_count <= prescaler_count + 3'h1;
        end
      end
    end
  end

  // Oscillator source: every cycle or every other cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_half <= 1'b0;
    end else begin
      osc_half <= !osc_half;
    end
  end

  assign oscillator_input = timer3_control[T3_OSC_HALF_BIT] ? osc_half : 1'b1;
  // Free-running 16-bit divider, underflow once per 65536 instruction ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer16 <= '0;
      t16_underflow <= 1'b0;
    end else begin
      t16_underflow <= instr_tick && (timer16 == '0);
      if (instr_tick) begin
        timer16 <= timer16 - 16'h0001;
      end
    end
  end

  // Watchdog stage counts falls of the fifteenth bit
  assign wdt_step = t16_watch_prev && !timer16[T16_WATCH_BIT];
  assign watchdog_expired = wdt_enable && (wdt_count == WDT_FIRE_COUNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t16_watch_prev <= 1'b0;
      wdt_count <= 2'h0;
    end else begin
      t16_watch_prev <= timer16[T16_WATCH_BIT];
      if (!wdt_enable || wr(OFF_WATCHDOG) && w_data[WDT_RESTART_BIT]) begin
        wdt_count <= 2'h0;
      end else if (wdt_step && wdt_count != WDT_FIRE_COUNT) begin
        wdt_count <= wdt_count + 2'h1;
      end
    end
  end

  // Source selection
  assign tick1 = prescaler_timer1_control[T1_SRC_BIT] ? carrier_rise : prescaler_output;
  always_comb begin
    unique case (timer2_control[T2_SRC_LSB +: 2])
      T2_SRC_PRESCALER: tick2 = prescaler_output;
      T2_SRC_TIMER1: tick2 = uf1;
      T2_SRC_INSTR: tick2 = instr_tick;
      T2_SRC_TIMER16: tick2 = t16_underflow;
    endcase
  end

  always_comb begin
    unique case (timer3_control[T3_SRC_LSB +: 2])
      T3_SRC_TIMER2: tick3 = uf2;
      T3_SRC_PRESCALER: tick3 = prescaler_output;
      T3_SRC_OSC: tick3 = oscillator_input;
      default: tick3 = 1'b0;
    endcase
  end

  reload_down_counter #(.WIDTH(T1_WIDTH)) timer1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(prescaler_timer1_control[T1_RUN_BIT]),
    .tick(tick1),
    .load(load1),
    .load_value({timer1_high_bits_holder, w_data[7:0]}),
    .reload_value(reload1),
    .count(count1),
    .underflow(uf1)
  );

  reload_down_counter #(.WIDTH(T23_WIDTH)) timer2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(timer2_control[T2_RUN_BIT]),
    .tick(tick2),
    .load(load2),
    .load_value(w_data[7:0]),
    .reload_value(reload2),
    .count(count2),
    .underflow(uf2)
  );

  reload_down_counter #(.WIDTH(T23_WIDTH)) timer3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(timer3_control[T3_RUN_BIT]),
    .tick(tick3),
    .load(load3),
    .load_value(w_data[7:0]),
    .reload_value(reload3),
    .count(count3),
    .underflow(uf3)
  );

  // Carrier from timer 3, gated by timer 1, and timer output from timer 2
  assign carrier_rise = uf3 && !carrier;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier <= 1'b0;
      carrier_gate <= 1'b0;
      carrier_out <= 1'b0;
      timer_out <= 1'b0;
      timer_out_select <= 1'b0;
    end else begin
      if (uf3) carrier <= !carrier;
      if (uf1) carrier_gate <= !carrier_gate;
      carrier_out <= carrier && carrier_gate;
      if (uf2) timer_out <= !timer_out;
      timer_out_select <= timer2_control[TOUT_SEL_BIT];
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  assign events = {watchdog_expired && wdt_step, t16_underflow, uf3, uf2, uf1};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else if (wr(OFF_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~w_data[IRQ_BITS-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// >>> reload_down_counter.sv
// Purpose: Reloadable down-counter with registered underflow pulse.
// Assumes: tick is a one-cycle enable on aclk.
// Notes: Underflow is registered so chained timers form no loop.
`timescale 1ns/1ps
`default_nettype none
module reload_down_counter #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] reload_value,
  output logic [WIDTH-1:0] count,
  output logic underflow
);
  logic at_zero;
  assign at_zero = (count == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (run && tick) begin
      if (at_zero) begin
        count <= reload_value;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underflow <= 1'b0;
    end else begin
      underflow <= run && tick && at_zero && !load;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the prescaled timer chain.
// Assumes: Instruction tick every 4 aclk; registered underflow pulses.
// Notes: Timer periods are measured between timer_out toggles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import timer_chain_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, last;
  logic irq, carrier_out, timer_out, timer_out_select, watchdog_expired;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  int pq[$];
  int n_fail, checked, cyc, tmo, seed, n;

  prescaled_timer_chain dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .carrier_out(carrier_out), .timer_out(timer_out), .timer_out_select(timer_out_select),
    .watchdog_expired(watchdog_expired));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    wq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ad = ad | awready;
      wd = wd | wready;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end while (!(ad && wd));
    do @(negedge aclk); while (bvalid !== 1'b1);
    // Late bready lets the response stand for a cycle
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Skips the first, possibly partial, period after a change
  task automatic meas(input int e);
    @(timer_out);
    repeat (2) @(negedge aclk);
    pq.push_back(e);
    @(timer_out);
    repeat (2) @(negedge aclk);
  endtask

  always @(negedge aclk) begin
    if (bvalid && bready) cmp({32'h0, bresp}, {32'h0, wq.pop_front()});
    if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
  end

  // Sampled between edges so no update races the look
  always @(negedge aclk) begin
    tmo++;
    if (timer_out !== last && pq.size() > 0) cmp(34'(cyc), 34'(pq.pop_front()));
    cyc = (timer_out !== last) ? 1 : cyc + 1;
    last = timer_out;
    if (tmo == 40000) begin
      n_fail++;
      report_and_stop;
    end
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, last} = 6'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    seed = 41080;
    {n_fail, checked, cyc, tmo} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Free 16-bit count at 0x28 moves at once, so it is left out; its wrap flag is already up
    for (int i = 0; i < 14; i++) begin
      if (i != 10) rd(6'(4 * i), (i == 11) ? 34'h8 : 34'h0);
    end
    rd(6'h38, {RESP_SLVERR, 32'h0});
    wr(6'h38, 32'h0, RESP_SLVERR);
    n = $random(seed) & 15;
    wr(OFF_PRESCALER_TIMER1_CONTROL, 32'h8, RESP_OKAY);
    wr(OFF_TIMER2_LOAD, 32'(n), RESP_OKAY);
    wr(OFF_TIMER2_CONTROL, 32'hC, RESP_OKAY);
    cmp(34'(timer_out_select), 34'h1);
    meas((n + 1) * 16);
    wr(OFF_PRESCALER_TIMER1_CONTROL, 32'hC, RESP_OKAY);
    meas((n + 1) * 32);
    wr(OFF_TIMER2_CONTROL, 32'hE, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 255 : $random(seed) & 255;
      wr(OFF_TIMER2_LOAD, 32'(n), RESP_OKAY);
      meas((n + 1) * 4);
    end
    wr(OFF_TIMER1_HIGH_BITS_HOLDER, 32'h1, RESP_OKAY);
    wr(OFF_TIMER1_LOAD, 32'h3, RESP_OKAY);
    wr(OFF_PRESCALER_TIMER1_CONTROL, 32'h9, RESP_OKAY);
    wr(OFF_TIMER2_LOAD, 32'h0, RESP_OKAY);
    wr(OFF_TIMER2_CONTROL, 32'hD, RESP_OKAY);
    meas(260 * 16);
    rd(OFF_TIMER1_HIGH_BITS_HOLDER, {RESP_OKAY, 32'h1});
    rd(OFF_TIMER1_LOAD, {RESP_OKAY, 32'h3});
    wr(OFF_TIMER2_CONTROL, 32'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    n = timer_out;
    // Next 16-bit wrap is far beyond this wait
    repeat (300) @(posedge aclk);
    cmp(34'(timer_out), 34'(n));
    wr(OFF_PRESCALER_TIMER1_CONTROL, 32'h8, RESP_OKAY);
    wr(OFF_TIMER2_CONTROL, 32'h0, RESP_OKAY);
    wr(OFF_IRQ_MASK, 32'h4, RESP_OKAY);
    wr(OFF_TIMER3_LOAD, 32'h1, RESP_OKAY);
    wr(OFF_TIMER3_CONTROL, 32'h9, RESP_OKAY);
    repeat (100) @(posedge aclk);
    wr(OFF_TIMER3_CONTROL, 32'h1, RESP_OKAY);
    cmp(34'(irq), 34'h1);
    rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'hF});
    wr(OFF_IRQ_STATUS, 32'hF, RESP_OKAY);
    cmp(34'(irq), 34'h0);
    wr(OFF_TIMER3_CONTROL, 32'hB, RESP_OKAY);
    repeat (100) @(posedge aclk);
    rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h0});
    wr(OFF_TIMER3_CONTROL, 32'hA, RESP_OKAY);
    repeat (20) @(posedge aclk);
    cmp(34'(irq), 34'h1);
    wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    cmp(34'(irq), 34'h0);
    wr(OFF_WATCHDOG, 32'h1, RESP_OKAY);
    rd(OFF_WATCHDOG, {RESP_OKAY, 32'h1});
    cmp(34'(watchdog_expired), 34'h0);
    // Timer 1 on carrier rises: timer 3 reload 1 at full rate rises every 4 cycles
    wr(OFF_TIMER1_HIGH_BITS_HOLDER, 32'h0, RESP_OKAY);
    wr(OFF_TIMER1_LOAD, 32'h1, RESP_OKAY);
    wr(OFF_PRESCALER_TIMER1_CONTROL, 32'hB, RESP_OKAY);
    wr(OFF_TIMER2_CONTROL, 32'hD, RESP_OKAY);
    meas(8);
    // Gate open 8 of every 16 cycles, carrier high 2 of every 4
    n = 0;
    repeat (64) begin
      @(negedge aclk);
      n += carrier_out;
    end
    cmp(34'(n), 34'h10);
    wr(OFF_TIMER3_CONTROL, 32'h1A, RESP_OKAY);
    meas(16);
    report_and_stop;
  end
endmodule
`default_nettype wire

// >>> timer_chain_assertions.sv
// Purpose: Port-level checks for the prescaled timer chain.
// Assumes: One aclk domain, synchronous active-low reset.
// Notes: Only top-level ports are visible, so timer internals are judged by effect.
`timescale 1ns/1ps
`default_nettype none
module timer_chain_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic timer_out,
  input wire logic timer_out_select,
  input wire logic watchdog_expired
);
  logic quiet;
  // No write offered or held, so no register write can take effect at the next edge
  assign quiet = s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid &&
    !s_axi_rvalid && !irq && !timer_out && !timer_out_select && !watchdog_expired)
    else $error("output not cleared by reset");
  chk_irq_sticky: assert property (irq && quiet |=> irq)
    else $error("interrupt dropped without a write");
  chk_wdt_sticky: assert property (watchdog_expired && quiet |=> watchdog_expired)
    else $error("watchdog expiry dropped without a write");
  chk_tsel_stable: assert property (quiet |=> $stable(timer_out_select))
    else $error("output select changed without a write");
endmodule
bind prescaled_timer_chain timer_chain_checker chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq), .timer_out(timer_out),
  .timer_out_select(timer_out_select), .watchdog_expired(watchdog_expired));
`default_nettype wire

// >>> timer_chain_pkg.sv
// Purpose: Shared constants for the prescaled timer chain.
// Assumes: 32-bit AXI4-Lite register bus, one word per register.
// Notes: Offsets are byte addresses.
package timer_chain_pkg;
  localparam logic [5:0] OFF_PRESCALER_TIMER1_CONTROL = 6'h00;
  localparam logic [5:0] OFF_TIMER2_CONTROL = 6'h04;
  localparam logic [5:0] OFF_TIMER3_CONTROL = 6'h08;
  localparam logic [5:0] OFF_TIMER1_LOAD = 6'h0C;
  localparam logic [5:0] OFF_TIMER1_HIGH_BITS_HOLDER = 6'h10;
  localparam logic [5:0] OFF_TIMER2_LOAD = 6'h14;
  localparam logic [5:0] OFF_TIMER3_LOAD = 6'h18;
  localparam logic [5:0] OFF_TIMER1_COUNT = 6'h1C;
  localparam logic [5:0] OFF_TIMER2_COUNT = 6'h20;
  localparam logic [5:0] OFF_TIMER3_COUNT = 6'h24;
  localparam logic [5:0] OFF_TIMER16_COUNT = 6'h28;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h2C;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h30;
  localparam logic [5:0] OFF_WATCHDOG = 6'h34;

  // Field positions, prescaler and timer 1 control
  localparam int T1_RUN_BIT = 0;
  localparam int T1_SRC_BIT = 1;
  localparam int PRE_RATIO_BIT = 2;
  localparam int PRE_RUN_BIT = 3;
  // Timer 2 control
  localparam int T2_SRC_LSB = 0;
  localparam int TOUT_SEL_BIT = 2;
  localparam int T2_RUN_BIT = 3;
  // Timer 3 control
  localparam int T3_SRC_LSB = 0;
  localparam int T3_SPARE_BIT = 2;
  localparam int T3_RUN_BIT = 3;
  localparam int T3_OSC_HALF_BIT = 4;
  // Interrupt status and mask
  localparam int IRQ_T1 = 0;
  localparam int IRQ_T2 = 1;
  localparam int IRQ_T3 = 2;
  localparam int IRQ_T16 = 3;
  localparam int IRQ_WDT = 4;
  localparam int IRQ_BITS = 5;
  // Watchdog register
  localparam int WDT_ENABLE_BIT = 0;
  localparam int WDT_RESTART_BIT = 1;

  localparam int T1_WIDTH = 10;
  localparam int T23_WIDTH = 8;
  localparam int T16_WIDTH = 16;
  localparam int T16_WATCH_BIT = 14;
  localparam logic [1:0] WDT_FIRE_COUNT = 2'h2;

  localparam logic [3:0] INSTR_DIV = 4'h4;
  localparam logic [2:0] PRE_DIV4_LAST = 3'h3;
  localparam logic [2:0] PRE_DIV8_LAST = 3'h7;

  localparam logic [1:0] T2_SRC_PRESCALER = 2'h0;
  localparam logic [1:0] T2_SRC_TIMER1 = 2'h1;
  localparam logic [1:0] T2_SRC_INSTR = 2'h2;
  localparam logic [1:0] T2_SRC_TIMER16 = 2'h3;
  localparam logic [1:0] T3_SRC_TIMER2 = 2'h0;
  localparam logic [1:0] T3_SRC_PRESCALER = 2'h1;
  localparam logic [1:0] T3_SRC_OSC = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
